// ==== hdl/mrq_writer.v ====
// monitor receive event queue writer with axi4-lite control registers
//
// Overview of operation
// - read target status first; if free, store bytes, then status with flag set
// - target still flagged: set queue overflow interrupt flag, drop the event
// - with time stamps entry adds timestamp word and an all-zero word
// - timestamp is the free counter captured when the monitor data arrived
// - link select bit is 0 for first multiplex, 1 for second
// - three-bit channel field names the channel on that multiplex
// - last with odd set: final byte sits in the following data word
// - last with odd clear: final byte was in previous entry of channel
// - last flag clear when neither data word nor previous entry ends it
// - first flag set only when following data word holds first byte
// - abort flag set when the received message was aborted
// - odd flag 1 for one byte in data word, 0 for two
// - under v* the odd, abort, first, last flags are 1, 0, 1, 1
// - gci low byte is a new byte seen twice; v* byte seen once
// - gci high byte is next double-seen byte; v* high byte all ones
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "mrq_map.vh"
module mrq_writer #(
    parameter MEM_AW = 16,
    parameter TS_W = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire mon_sample_valid,
    input wire mon_link,
    input wire [2:0] mon_channel,
    input wire [7:0] mon_byte,
    input wire mon_end_valid,
    input wire mon_end_link,
    input wire [2:0] mon_end_channel,
    input wire mon_end_abort,
    output reg mem_req,
    output reg mem_we,
    output reg [MEM_AW-1:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    output reg irq
);

    // ----------------------------------------------------------------
    // registers and shared state
    // ----------------------------------------------------------------
    localparam S_IDLE = 6'b000001;
    localparam S_READ = 6'b000010;
    localparam S_DATA = 6'b000100;
    localparam S_STAMP = 6'b001000;
    localparam S_ZERO = 6'b010000;
    localparam S_STAT = 6'b100000;

    reg [1:0] global_config_reg;
    reg [15:0] queue_base;
    reg [15:0] queue_size_reg;
    reg [2:0] interrupt_flags_reg;
    reg [2:0] int_mask;
    reg [15:0] wr_index;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [5:0] state;
    reg ev_valid;
    reg [15:0] ev_status;
    reg [15:0] ev_data;
    reg [TS_W-1:0] ev_stamp;
    reg ev_tse;
    reg [MEM_AW-1:0] entry_addr;
    reg [7:0] pend_byte [0:15];
    reg [15:0] pend_have;
    reg [15:0] pend_first;
    reg [15:0] in_msg;
    reg emit;
    reg [15:0] emit_status;
    reg [15:0] emit_data;
    reg [2:0] int_set;
    reg [2:0] int_clr;

    wire timestamp_enable = global_config_reg[`MRQ_CFG_TSE];
    wire vstar_mode = global_config_reg[`MRQ_CFG_VSTAR];
    wire f_valid;
    wire [3:0] f_slot;
    wire [7:0] f_byte;
    wire [TS_W-1:0] stamp_now;
    wire [3:0] end_slot = {mon_end_link, mon_end_channel};
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
        {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wval = w_data & wmask;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire mem_done = mem_req && mem_ack;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    mrq_gci_filter #(
        .SLOTS(16)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .vstar_mode(vstar_mode),
        .sample_valid(mon_sample_valid),
        .sample_slot({mon_link, mon_channel}),
        .sample_byte(mon_byte),
        .new_valid(f_valid),
        .new_slot(f_slot),
        .new_byte(f_byte)
    );

    mrq_stamp_counter #(
        .WIDTH(TS_W)
    ) u_stamp (
        .aclk(aclk),
        .aresetn(aresetn),
        .count(stamp_now)
    );

    // ----------------------------------------------------------------
    // event composition
    // ----------------------------------------------------------------
    // a byte and an end strobe on the same cycle: the byte is taken and
    // the end mark is ignored, so the source must space them apart
    always @* begin
        emit = 1'b0;
        emit_status = 16'h0000;
        emit_data = 16'h0000;
        emit_status[`MRQ_ST_LINK] = f_slot[3];
        emit_status[`MRQ_ST_CH_HI:`MRQ_ST_CH_LO] = f_slot[2:0];
        if (f_valid && vstar_mode) begin
            emit = 1'b1;
            emit_status[`MRQ_ST_ODD] = 1'b1;
            emit_status[`MRQ_ST_ABORT] = 1'b0;
            emit_status[`MRQ_ST_FIRST] = 1'b1;
            emit_status[`MRQ_ST_LAST] = 1'b1;
            emit_data = {`MRQ_VSTAR_HIGH, f_byte};
        end else if (f_valid && pend_have[f_slot]) begin
            emit = 1'b1;
            emit_status[`MRQ_ST_ODD] = 1'b0;
            emit_status[`MRQ_ST_FIRST] = pend_first[f_slot];
            emit_status[`MRQ_ST_LAST] = 1'b0;
            emit_data = {f_byte, pend_byte[f_slot]};
        end else if (!f_valid && mon_end_valid && !vstar_mode &&
                in_msg[end_slot]) begin
            emit = 1'b1;
            emit_status[`MRQ_ST_LINK] = end_slot[3];
            emit_status[`MRQ_ST_CH_HI:`MRQ_ST_CH_LO] = end_slot[2:0];
            emit_status[`MRQ_ST_ABORT] = mon_end_abort;
            emit_status[`MRQ_ST_LAST] = 1'b1;
            if (pend_have[end_slot]) begin
                emit_status[`MRQ_ST_ODD] = 1'b1;
                emit_status[`MRQ_ST_FIRST] = pend_first[end_slot];
                emit_data = {8'h00, pend_byte[end_slot]};
            end else begin
                emit_status[`MRQ_ST_ODD] = 1'b0;
                emit_status[`MRQ_ST_FIRST] = 1'b0;
            end
        end
    end

    // per-channel pairing of accepted bytes
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend_have <= 16'h0000;
            pend_first <= 16'h0000;
            in_msg <= 16'h0000;
        end else if (f_valid && !vstar_mode) begin
            if (pend_have[f_slot]) begin
                pend_have[f_slot] <= 1'b0;
            end else begin
                pend_byte[f_slot] <= f_byte;
                pend_have[f_slot] <= 1'b1;
                pend_first[f_slot] <= !in_msg[f_slot];
                in_msg[f_slot] <= 1'b1;
            end
        end else if (mon_end_valid && !vstar_mode) begin
            pend_have[end_slot] <= 1'b0;
            in_msg[end_slot] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // queue writer
    // ----------------------------------------------------------------
    // one event is held; a second one arriving while the writer is busy
    // is counted as lost rather than stalling the multiplex
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
            ev_valid <= 1'b0;
            ev_status <= 16'h0000;
            ev_data <= 16'h0000;
            ev_stamp <= {TS_W{1'b0}};
            ev_tse <= 1'b0;
            entry_addr <= {MEM_AW{1'b0}};
            wr_index <= 16'h0000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= {MEM_AW{1'b0}};
            mem_wdata <= 16'h0000;
            int_set <= 3'h0;
        end else begin
            int_set <= 3'h0;
            if (emit && !ev_valid) begin
                ev_valid <= 1'b1;
                ev_status <= emit_status;
                ev_data <= emit_data;
                ev_stamp <= stamp_now;
                ev_tse <= timestamp_enable;
            end else if (emit) begin
                int_set[`MRQ_INT_LOST] <= 1'b1;
            end
            case (state)
                S_IDLE: begin
                    if (ev_valid) begin
                        // entry stride is 2 or 4 words
                        entry_addr <= queue_base[MEM_AW-1:0] + (ev_tse ?
                            {wr_index[MEM_AW-3:0], 2'b00} :
                            {wr_index[MEM_AW-2:0], 1'b0});
                        mem_addr <= queue_base[MEM_AW-1:0] + (ev_tse ?
                            {wr_index[MEM_AW-3:0], 2'b00} :
                            {wr_index[MEM_AW-2:0], 1'b0});
                        mem_we <= 1'b0;
                        mem_req <= 1'b1;
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    if (mem_done) begin
                        if (mem_rdata[`MRQ_ST_VALID]) begin
                            mem_req <= 1'b0;
                            ev_valid <= 1'b0;
                            int_set[`MRQ_INT_OVF] <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            mem_we <= 1'b1;
                            mem_addr <= entry_addr + 1'b1;
                            mem_wdata <= ev_data;
                            state <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (mem_done) begin
                        if (ev_tse) begin
                            mem_addr <= entry_addr + 2'd2;
                            mem_wdata <= ev_stamp;
                            state <= S_STAMP;
                        end else begin
                            mem_addr <= entry_addr;
                            mem_wdata <= ev_status | 16'h8000;
                            state <= S_STAT;
                        end
                    end
                end
                S_STAMP: begin
                    if (mem_done) begin
                        mem_addr <= entry_addr + 2'd3;
                        mem_wdata <= 16'h0000;
                        state <= S_ZERO;
                    end
                end
                S_ZERO: begin
                    if (mem_done) begin
                        mem_addr <= entry_addr;
                        mem_wdata <= ev_status | 16'h8000;
                        state <= S_STAT;
                    end
                end
                S_STAT: begin
                    if (mem_done) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        ev_valid <= 1'b0;
                        int_set[`MRQ_INT_WRITTEN] <= 1'b1;
                        // wrap at the programmed entry count
                        if (wr_index + 1'b1 >= queue_size_reg) begin
                            wr_index <= 16'h0000;
                        end else begin
                            wr_index <= wr_index + 1'b1;
                        end
                        state <= S_IDLE;
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    // address and data are parked separately; readies reopen only after
    // the response is taken, so one write is in flight at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MRQ_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            global_config_reg <= `MRQ_CONFIG_RST;
            queue_base <= `MRQ_QBASE_RST;
            queue_size_reg <= `MRQ_QSIZE_RST;
            int_mask <= `MRQ_MASK_RST;
            int_clr <= 3'h0;
        end else begin
            int_clr <= 3'h0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MRQ_RESP_OKAY;
                case (aw_addr)
                    `MRQ_OFF_CONFIG: global_config_reg <= (global_config_reg &
                        ~wmask[1:0]) | wval[1:0];
                    `MRQ_OFF_QBASE: queue_base <= (queue_base &
                        ~wmask[15:0]) | wval[15:0];
                    `MRQ_OFF_QSIZE: queue_size_reg <= (queue_size_reg &
                        ~wmask[15:0]) | wval[15:0];
                    `MRQ_OFF_INT_FLAGS: int_clr <= wval[2:0];
                    `MRQ_OFF_INT_MASK: int_mask <= (int_mask &
                        ~wmask[2:0]) | wval[2:0];
                    `MRQ_OFF_QINDEX: s_axi_bresp <= `MRQ_RESP_OKAY;
                    default: s_axi_bresp <= `MRQ_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MRQ_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MRQ_RESP_OKAY;
                case (s_axi_araddr)
                    `MRQ_OFF_CONFIG: s_axi_rdata <= {30'h0, global_config_reg};
                    `MRQ_OFF_QBASE: s_axi_rdata <= {16'h0000, queue_base};
                    `MRQ_OFF_QSIZE: s_axi_rdata <= {16'h0000, queue_size_reg};
                    `MRQ_OFF_INT_FLAGS: s_axi_rdata <= {29'h0,
                        interrupt_flags_reg};
                    `MRQ_OFF_INT_MASK: s_axi_rdata <= {29'h0, int_mask};
                    `MRQ_OFF_QINDEX: s_axi_rdata <= {16'h0000, wr_index};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `MRQ_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    // a set in the clearing cycle survives: set is or-ed after the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_flags_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            interrupt_flags_reg <= (interrupt_flags_reg & ~int_clr) |
                int_set;
            irq <= |(interrupt_flags_reg & int_mask);
        end
    end

endmodule

// ==== hdl/mrq_map.vh ====
// register offsets, field positions and reset values of the monitor queue
`ifndef MRQ_MAP_VH
`define MRQ_MAP_VH

// ----------------------------------------------------------------
// register byte offsets on the axi4-lite port
// ----------------------------------------------------------------
`define MRQ_OFF_CONFIG 8'h00
`define MRQ_OFF_QBASE 8'h04
`define MRQ_OFF_QSIZE 8'h08
`define MRQ_OFF_INT_FLAGS 8'h0c
`define MRQ_OFF_INT_MASK 8'h10
`define MRQ_OFF_QINDEX 8'h14

// ----------------------------------------------------------------
// global_config_reg fields
// ----------------------------------------------------------------
`define MRQ_CFG_TSE 0
`define MRQ_CFG_VSTAR 1

// ----------------------------------------------------------------
// interrupt_flags_reg / mask fields
// ----------------------------------------------------------------
`define MRQ_INT_OVF 0
`define MRQ_INT_WRITTEN 1
`define MRQ_INT_LOST 2

// ----------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------
`define MRQ_ST_VALID 15
`define MRQ_ST_LINK 11
`define MRQ_ST_CH_HI 10
`define MRQ_ST_CH_LO 8
`define MRQ_ST_ODD 3
`define MRQ_ST_ABORT 2
`define MRQ_ST_FIRST 1
`define MRQ_ST_LAST 0

// ----------------------------------------------------------------
// reset values and fixed patterns
// ----------------------------------------------------------------
`define MRQ_CONFIG_RST 2'h0
`define MRQ_QBASE_RST 16'h0000
`define MRQ_QSIZE_RST 16'h0010
`define MRQ_MASK_RST 3'h0
`define MRQ_VSTAR_HIGH 8'hff
`define MRQ_RESP_OKAY 2'h0
`define MRQ_RESP_SLVERR 2'h2

`endif

// ==== hdl/mrq_stamp_counter.v ====
// free-running binary counter used to time-stamp monitor events
`timescale 1ns/10ps
module mrq_stamp_counter #(
    parameter WIDTH = 16
) (
    input wire aclk,
    input wire aresetn,
    output reg [WIDTH-1:0] count
);

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // wraps silently; software sees only relative time between entries
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= {WIDTH{1'b0}};
        end else begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ==== hdl/mrq_gci_filter.v ====
// per-slot monitor byte filter: double reception under gci, pass under v*
`timescale 1ns/10ps
module mrq_gci_filter #(
    parameter SLOTS = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire vstar_mode,
    input wire sample_valid,
    input wire [3:0] sample_slot,
    input wire [7:0] sample_byte,
    output reg new_valid,
    output reg [3:0] new_slot,
    output reg [7:0] new_byte
);

    reg [7:0] last_byte [0:SLOTS-1];
    reg [SLOTS-1:0] armed;

    // ----------------------------------------------------------------
    // per-slot history
    // ----------------------------------------------------------------
    // a slot re-arms only when the line changes, so a held byte is
    // reported once and not on every frame it stays on the line
    genvar s;
    generate
        for (s = 0; s < SLOTS; s = s + 1) begin : g_slot
            always @(posedge aclk) begin
                if (!aresetn) begin
                    last_byte[s] <= 8'h00;
                    armed[s] <= 1'b1;
                end else if (sample_valid && sample_slot == s) begin
                    last_byte[s] <= sample_byte;
                    if (sample_byte != last_byte[s]) begin
                        armed[s] <= 1'b1;
                    end else if (armed[s]) begin
                        armed[s] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // accepted byte strobe
    always @(posedge aclk) begin
        if (!aresetn) begin
            new_valid <= 1'b0;
            new_slot <= 4'h0;
            new_byte <= 8'h00;
        end else begin
            new_slot <= sample_slot;
            new_byte <= sample_byte;
            if (vstar_mode) begin
                new_valid <= sample_valid;
            end else begin
                new_valid <= sample_valid && armed[sample_slot] &&
                    sample_byte == last_byte[sample_slot];
            end
        end
    end

endmodule

// ==== tb/mrq_writer_asserts.sv ====
// port assertions for the monitor queue writer
`timescale 1ns/10ps
module mrq_writer_asserts #(parameter MEM_AW = 16) (
    input wire aclk, input wire aresetn,
    input wire s_axi_awvalid, input wire s_axi_awready,
    input wire s_axi_wvalid, input wire s_axi_wready,
    input wire s_axi_bvalid, input wire s_axi_arvalid,
    input wire s_axi_arready, input wire s_axi_rvalid,
    input wire s_axi_rready, input wire [31:0] s_axi_rdata,
    input wire mem_req, input wire mem_we, input wire mem_ack,
    input wire [MEM_AW-1:0] mem_addr,
    input wire [15:0] mem_wdata, input wire [15:0] mem_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // memory side: probe first, then write, never move a pending request
    a_req_stands: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request moved before ack");
    a_read_first: assert property (
        $rose(mem_req) |-> !mem_we)
        else $error("entry not probed before writing");
    a_free_write: assert property (
        mem_req && mem_ack && !mem_we && !mem_rdata[15] |=> mem_req && mem_we)
        else $error("free entry not written");
    a_full_drop: assert property (
        mem_req && mem_ack && !mem_we && mem_rdata[15] |=> !mem_req)
        else $error("flagged entry overwritten");
    // the last write of an entry is its status word, flag set, gaps zero
    a_status_shape: assert property (
        (mem_req && mem_we && mem_ack ##1 !mem_req) |->
        ($past(mem_wdata) & 16'hf0f0) == 16'h8000)
        else $error("status word malformed");
    // register port answers a read one cycle and a write two cycles after the take, and holds
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind mrq_writer mrq_writer_asserts #(.MEM_AW(MEM_AW)) chk_inst (.*);

// ==== tb/mrq_mem_model.sv ====
// shared memory model: word store with a varying ack delay
`timescale 1ns/10ps
module mrq_mem_model (
    input wire aclk, input wire mem_req, input wire mem_we,
    input wire [15:0] mem_addr, input wire [15:0] mem_wdata,
    output reg mem_ack, output reg [15:0] mem_rdata
);
    reg [15:0] mem [0:31];
    reg [2:0] cnt = 0;
    integer i;
    initial for (i = 0; i < 32; i = i + 1) mem[i] = 0;
    initial mem_ack = 0;
    initial mem_rdata = 0;
    // ack after one or two cycles; read data is garbage outside the ack
    always @(posedge aclk) begin
        cnt <= cnt + 1;
        mem_ack <= mem_req && !mem_ack && (cnt[0] || cnt[2]);
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && (cnt[0] || cnt[2])) begin
            if (mem_we) mem[mem_addr[4:0]] <= mem_wdata;
            else mem_rdata <= mem[mem_addr[4:0]];
        end
    end
    // host frees an entry after reading it
    task clear_entry(input [4:0] a);
        mem[a][15] = 0;
    endtask
endmodule

// ==== tb/tb_mrq_writer.sv ====
// self-checking bench for the monitor queue writer
`timescale 1ns/10ps
`include "mrq_map.vh"
module tb_mrq_writer;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready, s_axi_arvalid = 0, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, mem_req, mem_we, mem_ack;
    logic [7:0] s_axi_awaddr, s_axi_araddr, mon_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic mon_sample_valid = 0, mon_link, mon_end_valid;
    logic mon_end_link, mon_end_abort;
    logic [2:0] mon_channel, mon_end_channel;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [31:0] expq[$];
    integer errors = 0, tests_run = 0, seed = 80, cyc = 0, k;
    mrq_writer mrq_writer_inst (.*);
    mrq_mem_model mrq_mem_model_inst (.*);
    always #5 aclk = ~aclk;
    task chk(input [31:0] g, input [31:0] e);
        tests_run = tests_run + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task end_of_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_of_test;
        end
    end
    // each queue write is matched against the oldest note
    always @(posedge aclk) if (mem_req && mem_we && mem_ack) begin
        if (expq.size() == 0) chk({mem_addr, mem_wdata}, 32'hffff_ffff);
        else chk({mem_addr, mem_wdata}, expq.pop_front());
    end
    task wr(input [7:0] a, input [31:0] v);
        s_axi_awaddr <= a;
        {s_axi_wstrb, s_axi_wdata} <= {4'hf, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        @(posedge aclk);
        while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            @(posedge aclk);
        end
        s_axi_bready <= 0;
    endtask
    task rd(input [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        @(posedge aclk);
        while (s_axi_arvalid || !s_axi_rvalid) begin
            if (s_axi_arready) s_axi_arvalid <= 0;
            @(posedge aclk);
        end
        d = s_axi_rdata;
        s_axi_rready <= 0;
    endtask
    // one sample (e=0) or end strobe (e=1); abort rides on b[0]
    task mon(input e, input [3:0] lc, input [7:0] b);
        {mon_link, mon_channel} <= lc;
        {mon_end_link, mon_end_channel} <= lc;
        mon_byte <= b;
        mon_end_abort <= b[0];
        mon_sample_valid <= !e;
        mon_end_valid <= e;
        @(posedge aclk);
        mon_sample_valid <= 0;
        mon_end_valid <= 0;
        mon_byte <= $random(seed);
        repeat (12 + ($random(seed) & 3)) @(posedge aclk);
    endtask
    task g2(input [3:0] lc, input [7:0] b);
        mon(0, lc, b);
        mon(0, lc, b);
    endtask
    task drain;
        while (expq.size() != 0) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(`MRQ_OFF_QSIZE);
        chk(d, 32'h0000_0010);
        rd(8'h1c);
        chk(s_axi_rresp, `MRQ_RESP_SLVERR);
        wr(`MRQ_OFF_INT_MASK, 32'h0000_0001);
        expq.push_back(32'h0001_b2a1);
        expq.push_back(32'h0000_8b02);
        g2(4'hb, 8'ha1);
        g2(4'hb, 8'hb2);
        expq.push_back(32'h0003_00c3);
        expq.push_back(32'h0002_8b0d);
        g2(4'hb, 8'hc3);
        mon(1, 4'hb, 8'h01);
        expq.push_back(32'h0005_e5d4);
        expq.push_back(32'h0004_8702);
        g2(4'h7, 8'hd4);
        g2(4'h7, 8'he5);
        expq.push_back(32'h0007_0000);
        expq.push_back(32'h0006_8701);
        mon(1, 4'h7, 8'h00);
        drain;
        chk(irq, 0);
        wr(`MRQ_OFF_CONFIG, 32'h0000_0002);
        expq.push_back(32'h0009_ff5a);
        expq.push_back(32'h0008_850b);
        mon(0, 4'h5, 8'h5a);
        drain;
        // point the next entry back at a still-flagged location
        wr(`MRQ_OFF_QBASE, 32'h0000_fff6);
        mon(0, 4'h5, 8'h5b);
        for (k = 0; k < 100 && irq !== 1'b1; k = k + 1) @(posedge aclk);
        chk(irq, 1);
        rd(`MRQ_OFF_INT_FLAGS);
        chk(d[0], 1);
        wr(`MRQ_OFF_INT_FLAGS, 32'h0000_0001);
        repeat (3) @(posedge aclk);
        chk(irq, 0);
        mrq_mem_model_inst.clear_entry(0);
        expq.push_back(32'h0001_ff5c);
        expq.push_back(32'h0000_850b);
        mon(0, 4'h5, 8'h5c);
        drain;
        end_of_test;
    end
endmodule
